// ---- module_power_on_off_sequencer.sv ----
// device end: power-state sequencer of the cellular module
// assumes host pulls lines low open-drain; ms times scale by TICK_CYCLES
`timescale 1ns/10ps
`default_nettype none
module module_power_on_off_sequencer #(
    parameter int unsigned TICK_DIV = power_seq_pkg::TICK_CYCLES,
    parameter int unsigned ON_HOLD = power_seq_pkg::ON_HOLD_MS,
    parameter int unsigned OFF_HOLD = power_seq_pkg::OFF_HOLD_MS,
    parameter int unsigned FORCED_HOLD = power_seq_pkg::FORCED_HOLD_MS,
    parameter int unsigned BOOT = power_seq_pkg::BOOT_MS,
    parameter int unsigned PAD_CFG = power_seq_pkg::PAD_CFG_MS,
    parameter int unsigned SW_FINAL = power_seq_pkg::SW_FINAL_MS,
    parameter int unsigned HW_FINAL = power_seq_pkg::HW_FINAL_MS
) (
    input wire logic clk,
    input wire logic resetn,
    power_link_if.device link,
    input wire logic software_shutdown_command,
    input wire logic detach_done,
    output logic detach_request,
    output logic finalizing,
    output power_seq_pkg::dev_state_type state
);
    import power_seq_pkg::*;

    initial
    begin
        if (PAD_CFG >= BOOT || ON_HOLD == 0 || BOOT >= 2 ** MS_W
            || HW_FINAL >= 2 ** MS_W || OFF_HOLD >= 2 ** MS_W)
        begin
            $error("sequencer: timing parameters out of range");
        end
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] key_sync_q;
    logic [1:0] force_sync_q;
    logic key_low;
    logic force_low;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            key_sync_q <= 2'h3;
            force_sync_q <= 2'h3;
        end
        else
        begin
            key_sync_q <= {key_sync_q[0], link.power_key_n};
            force_sync_q <= {force_sync_q[0], link.forced_off_n};
        end
    end

    assign key_low = ~key_sync_q[1];
    assign force_low = ~force_sync_q[1];

    // ----------------------------------------------------------------
    // timebase and hold counters
    // ----------------------------------------------------------------
    logic tick;

    ms_timebase #(
        .DIV(TICK_DIV)
    ) u_tick (
        .clk(clk),
        .resetn(resetn),
        .tick(tick)
    );

    logic [MS_W-1:0] key_ms_q;
    logic [MS_W-1:0] key_ms_d;
    logic [MS_W-1:0] force_ms_q;
    logic [MS_W-1:0] force_ms_d;
    logic [MS_W-1:0] st_ms_q;
    logic [MS_W-1:0] st_ms_d;
    logic key_seen_q;
    logic key_seen_d;
    logic hw_off_q;
    logic hw_off_d;
    logic detach_q;
    logic detach_d;
    logic pg_q;
    logic pg_d;
    logic rdy_q;
    logic rdy_d;
    dev_state_type st_q;
    dev_state_type st_d;

    // counters saturate; forced-off abort is checked on release
    always_comb
    begin
        key_ms_d = key_ms_q;
        force_ms_d = force_ms_q;
        if (!key_low)
            key_ms_d = '0;
        else if (tick && key_ms_q != {MS_W{1'b1}})
            key_ms_d = key_ms_q + 1'b1;
        if (!force_low)
            force_ms_d = '0;
        else if (tick && force_ms_q != {MS_W{1'b1}})
            force_ms_d = force_ms_q + 1'b1;
    end

    // ----------------------------------------------------------------
    // power state machine
    // ----------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_ms_d = st_ms_q;
        key_seen_d = key_seen_q;
        hw_off_d = hw_off_q;
        detach_d = 1'b0;
        pg_d = pg_q;
        rdy_d = rdy_q;
        if (tick && st_ms_q != {MS_W{1'b1}})
            st_ms_d = st_ms_q + 1'b1;
        unique case (st_q)
            ST_OFF:
            begin
                pg_d = 1'b0;
                rdy_d = 1'b0;
                // tied-low key counts as a long press from supply-up
                if (key_low && key_ms_q >= MS_W'(ON_HOLD))
                begin
                    st_d = ST_BOOT;
                    st_ms_d = key_ms_q;
                end
            end
            ST_BOOT:
            begin
                if (st_ms_q >= MS_W'(PAD_CFG))
                    pg_d = 1'b1;
                if (st_ms_q >= MS_W'(BOOT))
                begin
                    st_d = ST_ACTIVE;
                    rdy_d = 1'b1;
                    key_seen_d = key_low;
                end
            end
            ST_ACTIVE:
            begin
                // held key from power-on must be released first
                if (!key_low)
                    key_seen_d = 1'b0;
                if (software_shutdown_command)
                begin
                    st_d = ST_FINAL;
                    hw_off_d = 1'b0;
                    st_ms_d = '0;
                    detach_d = 1'b1;
                    rdy_d = 1'b0;
                end
                else if (!key_seen_q && key_ms_q > MS_W'(OFF_HOLD))
                begin
                    st_d = ST_FINAL;
                    hw_off_d = 1'b1;
                    st_ms_d = '0;
                    detach_d = 1'b1;
                    rdy_d = 1'b0;
                end
            end
            ST_FINAL:
            begin
                if (detach_done && st_ms_q >=
                    (hw_off_q ? MS_W'(HW_FINAL) : MS_W'(SW_FINAL)))
                begin
                    st_d = ST_RELEASE;
                end
            end
            ST_RELEASE:
            begin
                pg_d = 1'b0;
                if (!key_low)
                    st_d = ST_OFF;
            end
            default:
            begin
                st_d = ST_OFF;
                pg_d = 1'b0;
                rdy_d = 1'b0;
            end
        endcase
        // unconditional exit: acts on release after a long enough hold
        if (!force_low && force_ms_q >= MS_W'(FORCED_HOLD)
            && st_q != ST_OFF)
        begin
            st_d = ST_RELEASE;
            pg_d = 1'b0;
            rdy_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q <= ST_OFF;
            st_ms_q <= '0;
            key_ms_q <= '0;
            force_ms_q <= '0;
            key_seen_q <= 1'b0;
            hw_off_q <= 1'b0;
            detach_q <= 1'b0;
            pg_q <= 1'b0;
            rdy_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            st_ms_q <= st_ms_d;
            key_ms_q <= key_ms_d;
            force_ms_q <= force_ms_d;
            key_seen_q <= key_seen_d;
            hw_off_q <= hw_off_d;
            detach_q <= detach_d;
            pg_q <= pg_d;
            rdy_q <= rdy_d;
        end
    end

    assign link.power_good_monitor = pg_q;
    assign link.firmware_ready = rdy_q;
    assign detach_request = detach_q;
    assign finalizing = (st_q == ST_FINAL);
    assign state = st_q;
endmodule : module_power_on_off_sequencer
`default_nettype wire

// ---- power_seq_pkg.sv ----
// constants and types shared by both ends of the power sequencer link
// assumes a single 200 MHz clock on both ends
package power_seq_pkg;
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned ON_HOLD_MS = 1000;
    localparam int unsigned OFF_HOLD_MS = 2500;
    localparam int unsigned FORCED_HOLD_MS = 200;
    localparam int unsigned BOOT_MS = 20000;
    localparam int unsigned PAD_CFG_MS = 10000;
    localparam int unsigned SW_FINAL_MS = 10000;
    localparam int unsigned HW_FINAL_MS = 15000;
    localparam int unsigned MS_W = 16;

    typedef enum logic [4:0] {
        ST_OFF = 5'b0_0001,
        ST_BOOT = 5'b0_0010,
        ST_ACTIVE = 5'b0_0100,
        ST_FINAL = 5'b0_1000,
        ST_RELEASE = 5'b1_0000
    } dev_state_type;

    typedef enum logic [3:0] {
        HS_IDLE = 4'b0001,
        HS_PRESS = 4'b0010,
        HS_FORCE = 4'b0100,
        HS_WAIT = 4'b1000
    } host_state_type;
endpackage : power_seq_pkg

// ---- power_link_if.sv ----
// control and status lines between host and module
// resolves open-drain lines from enables; pull-ups model the device's
`timescale 1ns/10ps
`default_nettype none
interface power_link_if;
    logic power_key_oe;
    logic forced_off_oe;
    logic power_key_n;
    logic forced_off_n;
    logic power_good_monitor;
    logic firmware_ready;

    // host only pulls low; device pull-up keeps the line high otherwise
    assign power_key_n = ~power_key_oe;
    assign forced_off_n = ~forced_off_oe;

    modport device (
        input power_key_n,
        input forced_off_n,
        output power_good_monitor,
        output firmware_ready
    );
    modport host (
        output power_key_oe,
        output forced_off_oe,
        input power_good_monitor,
        input firmware_ready
    );
endinterface : power_link_if
`default_nettype wire

// ---- ms_timebase.sv ----
// millisecond tick divider, one tick pulse every DIV cycles
// assumes inputs already synchronised to clk
`timescale 1ns/10ps
`default_nettype none
module ms_timebase #(
    parameter int unsigned DIV = power_seq_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    output logic tick
);
    import power_seq_pkg::*;
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;

    initial
    begin
        if (DIV < 1)
        begin
            $error("ms_timebase: DIV must be at least 1");
        end
    end

    always_comb
    begin
        if (cnt_q >= DIV - 1)
            cnt_d = '0;
        else
            cnt_d = cnt_q + 32'h0000_0001;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end

    assign tick = (cnt_q == DIV - 1);
endmodule : ms_timebase
`default_nettype wire

// ---- power_host_ctrl.sv ----
// host end: pulls the key and forced-off lines, watches status
// assumes the device end sits on the same clock
`timescale 1ns/10ps
`default_nettype none
module power_host_ctrl #(
    parameter int unsigned TICK_DIV = power_seq_pkg::TICK_CYCLES,
    parameter int unsigned ON_HOLD = power_seq_pkg::ON_HOLD_MS,
    parameter int unsigned OFF_HOLD = power_seq_pkg::OFF_HOLD_MS,
    parameter int unsigned FORCED_HOLD = power_seq_pkg::FORCED_HOLD_MS
) (
    input wire logic clk,
    input wire logic resetn,
    power_link_if.host link,
    input wire logic power_on_req,
    input wire logic power_off_req,
    input wire logic emergency_req,
    output logic busy,
    output logic module_ready,
    output logic module_off
);
    import power_seq_pkg::*;

    initial
    begin
        if (OFF_HOLD >= 2 ** MS_W || ON_HOLD == 0 || FORCED_HOLD == 0)
        begin
            $error("host: timing parameters out of range");
        end
    end

    logic tick;

    ms_timebase #(
        .DIV(TICK_DIV)
    ) u_tick (
        .clk(clk),
        .resetn(resetn),
        .tick(tick)
    );

    host_state_type st_q;
    host_state_type st_d;
    logic [MS_W-1:0] ms_q;
    logic [MS_W-1:0] ms_d;
    logic [MS_W-1:0] hold_q;
    logic [MS_W-1:0] hold_d;
    logic pg_wait_q;
    logic pg_wait_d;

    // one extra ms so the device sees strictly more than the hold
    always_comb
    begin
        st_d = st_q;
        ms_d = ms_q;
        hold_d = hold_q;
        pg_wait_d = pg_wait_q;
        if (tick)
            ms_d = ms_q + 1'b1;
        unique case (st_q)
            HS_IDLE:
            begin
                ms_d = '0;
                if (emergency_req)
                begin
                    st_d = HS_FORCE;
                    hold_d = MS_W'(FORCED_HOLD);
                    pg_wait_d = 1'b0;
                end
                else if (power_on_req && !link.power_good_monitor)
                begin
                    st_d = HS_PRESS;
                    hold_d = MS_W'(ON_HOLD);
                    pg_wait_d = 1'b1;
                end
                else if (power_off_req && link.firmware_ready)
                begin
                    st_d = HS_PRESS;
                    hold_d = MS_W'(OFF_HOLD + 1);
                    pg_wait_d = 1'b0;
                end
            end
            HS_PRESS, HS_FORCE:
            begin
                // ticks run free of the press: one spare tick covers
                // the partial first period, so the hold is never short
                if (ms_q > hold_q)
                    st_d = HS_WAIT;
            end
            HS_WAIT:
            begin
                // on: wait ready; off: wait power_good low
                if (pg_wait_q ? link.firmware_ready
                              : !link.power_good_monitor)
                    st_d = HS_IDLE;
                else if (emergency_req)
                begin
                    st_d = HS_FORCE;
                    ms_d = '0;
                    hold_d = MS_W'(FORCED_HOLD);
                    pg_wait_d = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q <= HS_IDLE;
            ms_q <= '0;
            hold_q <= '0;
            pg_wait_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            ms_q <= ms_d;
            hold_q <= hold_d;
            pg_wait_q <= pg_wait_d;
        end
    end

    // open-drain only: enable pulls low, never drives high
    assign link.power_key_oe = (st_q == HS_PRESS);
    assign link.forced_off_oe = (st_q == HS_FORCE);
    assign busy = (st_q != HS_IDLE);
    assign module_ready = link.firmware_ready;
    assign module_off = ~link.power_good_monitor;
endmodule : power_host_ctrl
`default_nettype wire

// ---- power_link_props.sv ----
// assertions on the host to device power link
// assumes one clock and the scaled ms parameters set by the bench
`timescale 1ns/10ps
`default_nettype none
module power_link_props #(
    parameter int unsigned TICK_DIV = 4,
    parameter int unsigned ON_HOLD = 3,
    parameter int unsigned OFF_HOLD = 6,
    parameter int unsigned FORCED_HOLD = 2,
    parameter int unsigned BOOT = 20,
    parameter int unsigned PAD_CFG = 10,
    parameter int unsigned HW_FINAL = 12
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic power_key_n,
    input wire logic forced_off_n,
    input wire logic power_good_monitor,
    input wire logic firmware_ready
);
    // slack covers the input sync and a partial first tick
    localparam int unsigned RDY_LO = (BOOT - 1) * TICK_DIV;
    localparam int unsigned RDY_HI = (BOOT + 1) * TICK_DIV + 6;
    localparam int unsigned PG_LO = (PAD_CFG - 1) * TICK_DIV;
    localparam int unsigned PG_HI = (PAD_CFG + 1) * TICK_DIV + 6;
    localparam int unsigned FIN_LO = (OFF_HOLD + HW_FINAL - 1) * TICK_DIV;
    logic [31:0] age_q, age_d, low_q, low_d, frc_q, frc_d;
    logic prev_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // ----------------------------------------
    // cycles since key fell, low run lengths
    // ----------------------------------------
    always_comb
    begin
        age_d = (!power_key_n && prev_q) ? 32'h0000_0000 : age_q + 32'h1;
        low_d = power_key_n ? 32'h0000_0000 : low_q + 32'h0000_0001;
        frc_d = forced_off_n ? 32'h0000_0000 : frc_q + 32'h0000_0001;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            age_q <= 32'h0000_0000;
            low_q <= 32'h0000_0000;
            frc_q <= 32'h0000_0000;
            prev_q <= 1'b1;
        end
        else
        begin
            age_q <= age_d;
            low_q <= low_d;
            frc_q <= frc_d;
            prev_q <= power_key_n;
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    ready_needs_pg_a:
        assert property (firmware_ready |-> power_good_monitor)
        else $error("ready without power good");
    ready_time_a:
        assert property ($rose(firmware_ready) |-> age_q >= RDY_LO
            && age_q <= RDY_HI) else $error("ready at wrong time");
    pg_time_a:
        assert property ($rose(power_good_monitor) |-> age_q >= PG_LO
            && age_q <= PG_HI) else $error("power good at wrong time");
    off_clears_ready_a:
        assert property ($fell(power_good_monitor) |-> !firmware_ready)
        else $error("ready still high when off");
    off_stays_a:
        assert property ($fell(power_good_monitor) |=>
            !power_good_monitor [*4]) else $error("power good bounced");
    final_min_a:
        assert property ($fell(power_good_monitor) |-> age_q >= FIN_LO)
        else $error("finalization too short");
    key_hold_a:
        assert property ($rose(power_key_n) |-> low_q >= ON_HOLD * TICK_DIV)
        else $error("key press too short");
    off_hold_a:
        assert property ($rose(power_key_n) && power_good_monitor
            |-> low_q > OFF_HOLD * TICK_DIV) else $error("off press short");
    forced_hold_a:
        assert property ($rose(forced_off_n) |->
            frc_q >= FORCED_HOLD * TICK_DIV) else $error("forced too short");
endmodule : power_link_props
`default_nettype wire

// ---- module_power_on_off_sequencer_tb.sv ----
// bench: host end against device end, plus a bench-driven device end
// assumes the package's state encodings; ms times scaled down
`timescale 1ns/10ps
`default_nettype none
module module_power_on_off_sequencer_tb;
    import power_seq_pkg::*;
    localparam int unsigned TD = 4;
    localparam int unsigned ONH = 3;
    localparam int unsigned OFH = 6;
    localparam int unsigned FH = 2;
    localparam int unsigned BT = 20;
    localparam int unsigned PC = 10;
    localparam int unsigned SF = 8;
    localparam int unsigned HF = 12;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic on_req = 1'b0;
    logic off_req = 1'b0;
    logic emg_req = 1'b0;
    logic sw_cmd = 1'b0;
    logic det_done = 1'b1;
    logic m_ready, m_off, det_req, fin, h_busy;
    dev_state_type st, st_b;
    int err_count = 0;
    int total_checks = 0;
    int det_cnt = 0;
    int n, d0;

    power_link_if link_a ();
    power_link_if link_b ();

    always #2.5 clk = ~clk;
    always @(posedge clk) if (det_req === 1'b1) det_cnt <= det_cnt + 1;

    module_power_on_off_sequencer #(.TICK_DIV(TD), .ON_HOLD(ONH),
        .OFF_HOLD(OFH), .FORCED_HOLD(FH), .BOOT(BT), .PAD_CFG(PC),
        .SW_FINAL(SF), .HW_FINAL(HF)) u_module_power_on_off_sequencer (
        .clk(clk), .resetn(resetn), .link(link_a.device),
        .software_shutdown_command(sw_cmd), .detach_done(det_done),
        .detach_request(det_req), .finalizing(fin), .state(st));
    // second device end: bench pulls its lines to break the host's habits
    module_power_on_off_sequencer #(.TICK_DIV(TD), .ON_HOLD(ONH),
        .OFF_HOLD(OFH), .FORCED_HOLD(FH), .BOOT(BT), .PAD_CFG(PC),
        .SW_FINAL(SF), .HW_FINAL(HF)) u_module_power_on_off_sequencer_b (
        .clk(clk), .resetn(resetn), .link(link_b.device),
        .software_shutdown_command(1'b0), .detach_done(1'b1),
        .detach_request(), .finalizing(), .state(st_b));
    power_host_ctrl #(.TICK_DIV(TD), .ON_HOLD(ONH), .OFF_HOLD(OFH),
        .FORCED_HOLD(FH)) u_power_host_ctrl (
        .clk(clk), .resetn(resetn), .link(link_a.host),
        .power_on_req(on_req), .power_off_req(off_req),
        .emergency_req(emg_req), .busy(h_busy), .module_ready(m_ready),
        .module_off(m_off));
    power_link_props #(.TICK_DIV(TD), .ON_HOLD(ONH), .OFF_HOLD(OFH),
        .FORCED_HOLD(FH), .BOOT(BT), .PAD_CFG(PC), .HW_FINAL(HF))
        u_power_link_props (.clk(clk), .resetn(resetn),
        .power_key_n(link_a.power_key_n),
        .forced_off_n(link_a.forced_off_n),
        .power_good_monitor(link_a.power_good_monitor),
        .firmware_ready(link_a.firmware_ready));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    function automatic logic probe(input int sel);
        case (sel)
            0: return link_a.power_good_monitor;
            1: return link_a.firmware_ready;
            default: return link_b.firmware_ready;
        endcase
    endfunction : probe

    // sampled on the falling edge, clear of the launching edge
    task wait_for(input int sel, input logic v, input int lim);
        n = 0;
        while (probe(sel) !== v && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= lim)
        begin
            check(probe(sel), v);
        end
    endtask : wait_for

    task pulse(input int k);
        @(posedge clk);
        case (k)
            0: on_req <= 1'b1;
            1: off_req <= 1'b1;
            2: emg_req <= 1'b1;
            default: sw_cmd <= 1'b1;
        endcase
        @(posedge clk);
        on_req <= 1'b0;
        off_req <= 1'b0;
        emg_req <= 1'b0;
        sw_cmd <= 1'b0;
    endtask : pulse

    task give_verdict;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial
    begin
        link_b.power_key_oe <= 1'b1;
        link_b.forced_off_oe <= 1'b0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        wait_for(2, 1'b1, (BT + 4) * TD);
        check(link_b.power_good_monitor, 1'b1);
        @(posedge clk);
        link_b.power_key_oe <= 1'b0;
        repeat (2 * TD) @(posedge clk);
        link_b.power_key_oe <= 1'b1;
        repeat ((OFH - 2) * TD) @(posedge clk);
        link_b.power_key_oe <= 1'b0;
        link_b.forced_off_oe <= 1'b1;
        repeat (TD - 2) @(posedge clk);
        link_b.forced_off_oe <= 1'b0;
        repeat ((OFH + HF + 4) * TD) @(posedge clk);
        check(32'(st_b), 32'(ST_ACTIVE));
        check(link_b.power_good_monitor, 1'b1);
        pulse(1);
        repeat (4) @(posedge clk);
        check(link_a.power_key_oe, 1'b0);
        check(h_busy, 1'b0);
        pulse(0);
        wait_for(1, 1'b1, (BT + 4) * TD);
        check(n >= (BT - 1) * TD && n <= (BT + 1) * TD + 8, 1'b1);
        check(m_ready, 1'b1);
        check(32'(st), 32'(ST_ACTIVE));
        d0 = det_cnt;
        pulse(3);
        repeat (4) @(posedge clk);
        check(fin, 1'b1);
        check(det_cnt - d0, 1);
        wait_for(0, 1'b0, (SF + 4) * TD);
        check(n >= (SF - 2) * TD && n <= (SF + 1) * TD + 8, 1'b1);
        check(m_ready, 1'b0);
        repeat (4) @(posedge clk);
        check(32'(st), 32'(ST_OFF));
        pulse(0);
        wait_for(1, 1'b1, (BT + 6) * TD);
        @(posedge clk);
        det_done <= 1'b0;
        d0 = det_cnt;
        pulse(1);
        // detach held back: power must stay up past the final count
        repeat ((OFH + HF + 4) * TD) @(negedge clk);
        check(link_a.power_good_monitor, 1'b1);
        check(h_busy, 1'b1);
        check(det_cnt - d0, 1);
        check(fin, 1'b1);
        @(posedge clk);
        det_done <= 1'b1;
        wait_for(0, 1'b0, 8 * TD);
        check(m_off, 1'b1);
        pulse(0);
        wait_for(1, 1'b1, (BT + 6) * TD);
        pulse(2);
        wait_for(0, 1'b0, (FH + 4) * TD);
        check(n >= (FH - 1) * TD && n <= (FH + 2) * TD + 8, 1'b1);
        repeat (4) @(posedge clk);
        check(32'(st), 32'(ST_OFF));
        give_verdict();
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        err_count++;
        give_verdict();
    end
endmodule : module_power_on_off_sequencer_tb
`default_nettype wire
